// [hw/ddrwp_core.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Write: select, column, write low; row high
// - Write latency is additive plus CAS minus one
// - Remaining bits on both strobe edges, BL4/BL8
// - Data after burst end is ignored
// - One mask per byte, timed like data
// - Mask ignored during reads
// - Precharge: select, row, write low; column high
// - Bit 10 high closes all, else one
// - Bit 10 on access selects auto-precharge
// - Write auto-precharge waits for stored data
// - Auto-precharge held until active time met
// - Read auto-precharge after AL plus BL/2
// - Precharge never before prefetch plus tRTP; only read auto-precharge is held to it, explicit precharge is not
// - Read: select, column low; row, write high
module ddrwp_core
   import ddrwp_pkg::*;
#(
   parameter int ADDR_W = ADDR_WIDTH,
   parameter int DQ_W = DQ_WIDTH
) (
   // System clock and reset
   input wire logic CLOCK,
   input wire logic RST_N,
   // Command clock and command pins
   input wire logic CK,
   input wire logic CS_N,
   input wire logic RAS_N,
   input wire logic CAS_N,
   input wire logic WE_N,
   input wire logic [BA_WIDTH-1:0] BA,
   input wire logic [ADDR_W-1:0] ADDR,
   // Write data pins
   input wire logic DQS_IN,
   input wire logic [DQ_W-1:0] DQ_IN,
   input wire logic [DQ_W/DM_GROUP-1:0] DM,
   // Static mode settings
   input wire logic [2:0] CAS_LATENCY,
   input wire logic [2:0] ADD_LATENCY,
   input wire logic BURST_LEN8,
   // Captured write beats toward the array
   output logic WR_VALID,
   output logic [DQ_W-1:0] WR_DATA,
   output logic [DQ_W/DM_GROUP-1:0] WR_MASK,
   output logic [2:0] WR_BEAT,
   output logic [BA_WIDTH-1:0] WR_BANK,
   output logic [ADDR_W-1:0] WR_COL,
   // Bank state
   output logic [BANKS-1:0] BANK_OPEN,
   output logic [BANKS-1:0] PRECHARGE_START
);

   localparam int DM_W = DQ_W / DM_GROUP;
   localparam int SW = 6 + BA_WIDTH + ADDR_W + DQ_W + DM_W;

   // =================================================================
   // Pin synchroniser
   // =================================================================
   logic [SW-1:0] sync1_q;  // First stage, read only by the second
   logic [SW-1:0] sync2_q;  // Stable copy of all pins
   logic ck_q;              // Previous command clock level
   logic dqs_q;             // Previous strobe level
   wire ck_s, dqs_s, cs_n_s, ras_n_s, cas_n_s, we_n_s;
   wire [BA_WIDTH-1:0] ba_s;
   wire [ADDR_W-1:0] addr_s;
   wire [DQ_W-1:0] dq_s;
   wire [DM_W-1:0] dm_s;

   // Data and strobe share one delay, so the strobe edge still sits
   // inside the data eye after the crossing
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         sync1_q <= '0;
         sync2_q <= '0;
         ck_q <= 1'b0;
         dqs_q <= 1'b0;
      end else begin
         sync1_q <= {CK, DQS_IN, CS_N, RAS_N, CAS_N, WE_N, BA, ADDR, DQ_IN, DM};
         sync2_q <= sync1_q;
         ck_q <= ck_s;
         dqs_q <= dqs_s;
      end
   end

   assign {ck_s, dqs_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, addr_s, dq_s, dm_s} = sync2_q;

   // =================================================================
   // Command decode
   // =================================================================
   // Bank number to one-hot select
   function automatic logic [BANKS-1:0] bank_onehot(input logic [BA_WIDTH-1:0] ba);
      bank_onehot = '0;
      bank_onehot[ba] = 1'b1;
   endfunction : bank_onehot

   wire ck_rise = ck_s & ~ck_q;          // Command sampling edge
   wire dqs_rise = dqs_s & ~dqs_q;
   wire dqs_fall = ~dqs_s & dqs_q;
   wire cmd_en = ck_rise & ~cs_n_s;
   wire act_cmd = cmd_en & ~ras_n_s & cas_n_s & we_n_s;
   wire rd_cmd = cmd_en & ras_n_s & ~cas_n_s & we_n_s;
   wire wr_cmd = cmd_en & ras_n_s & ~cas_n_s & ~we_n_s;
   wire pre_cmd = cmd_en & ~ras_n_s & cas_n_s & ~we_n_s;
   wire ap_flag = addr_s[AP_BIT];
   wire [BANKS-1:0] cmd_oh = bank_onehot(ba_s);
   // All banks or the addressed bank
   wire [BANKS-1:0] pre_sel = ap_flag ? {BANKS{1'b1}} : cmd_oh;

   // =================================================================
   // Write burst sequencer
   // =================================================================
   ddrwp_wstate_t wr_state_q, wr_state_d;
   logic [3:0] wl_cnt_q;           // Command clocks left to the latency point
   logic [3:0] beat_q;             // Beats taken so far
   logic wr_ap_q;                  // Write carries auto-precharge
   logic [BA_WIDTH-1:0] wr_bank_q;
   logic [ADDR_W-1:0] wr_col_q;
   logic wr_valid_q;
   logic [DQ_W-1:0] wr_data_q;
   logic [DM_W-1:0] wr_mask_q;
   logic [2:0] wr_beat_q;
   logic [3:0] wl_seen_q;          // Checking aid: clocks since write

   wire [3:0] wl = {1'b0, ADD_LATENCY} + {1'b0, CAS_LATENCY} - WL_OFFSET;
   wire [3:0] bl_beats = BURST_LEN8 ? BL8_BEATS : BL4_BEATS;
   wire in_burst = (wr_state_q == W_BURST);
   // First beat needs a rising edge, so the preamble low is skipped
   wire first_edge = (beat_q == 4'h0) ? dqs_rise : (dqs_rise | dqs_fall);
   wire beat_take = in_burst & first_edge;
   wire last_beat = beat_take & (beat_q == bl_beats - 4'h1);
   wire wr_start = (wr_state_q == W_IDLE) & wr_cmd;

   // Next state; a write during a burst is not queued
   always_comb begin
      wr_state_d = wr_state_q;
      case (wr_state_q)
         W_IDLE: begin
            if (wr_cmd) begin
               wr_state_d = W_WAIT;
            end
         end
         W_WAIT: begin
            if (ck_rise && wl_cnt_q == 4'h1) begin
               wr_state_d = W_BURST;
            end
         end
         W_BURST: begin
            if (last_beat) begin
               wr_state_d = W_IDLE;
            end
         end
         default: begin
            wr_state_d = W_IDLE;
         end
      endcase
   end

   // State register and latency counter
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         wr_state_q <= W_IDLE;
         wl_cnt_q <= 4'h0;
      end else begin
         wr_state_q <= wr_state_d;
         if (wr_start) begin
            wl_cnt_q <= wl;
         end else if (ck_rise && wl_cnt_q != 4'h0) begin
            wl_cnt_q <= wl_cnt_q - 4'h1;
         end
      end
   end

   // Command fields held for the burst
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         wr_ap_q <= 1'b0;
         wr_bank_q <= '0;
         wr_col_q <= '0;
      end else if (wr_start) begin
         wr_ap_q <= ap_flag;
         wr_bank_q <= ba_s;
         wr_col_q <= addr_s;
      end
   end

   // Beat capture; data and mask are taken only inside the burst
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         beat_q <= 4'h0;
         wr_valid_q <= 1'b0;
         wr_data_q <= '0;
         wr_mask_q <= '0;
         wr_beat_q <= 3'h0;
      end else begin
         wr_valid_q <= beat_take;
         if (wr_start) begin
            beat_q <= 4'h0;
         end else if (beat_take) begin
            beat_q <= beat_q + 4'h1;
            wr_data_q <= dq_s;
            wr_mask_q <= dm_s;
            wr_beat_q <= beat_q[2:0];
         end
      end
   end

   // Checking aid: command clocks since the write
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         wl_seen_q <= 4'h0;
      end else if (wr_start) begin
         wl_seen_q <= 4'h0;
      end else if (ck_rise && wl_seen_q != 4'hF) begin
         wl_seen_q <= wl_seen_q + 4'h1;
      end
   end

   // =================================================================
   // Banks and auto-precharge
   // =================================================================
   logic [BANKS-1:0] pre_evt_q;
   wire [BANKS-1:0] bank_open;
   wire [BANKS-1:0] ap_fire;
   // Read start: later of AL+BL/2 and last prefetch plus tRTP
   wire [7:0] al8 = {5'h00, ADD_LATENCY};
   wire [7:0] rd_half = al8 + (BURST_LEN8 ? BL8_HALF : BL4_HALF);
   wire [7:0] rd_rtp = al8 + (BURST_LEN8 ? BL8_PREFETCH : 8'h00) + TRTP_DLY;
   wire [7:0] rd_ap_dly = (rd_half > rd_rtp) ? rd_half : rd_rtp;
   wire rd_arm = rd_cmd & ap_flag;
   // Recovery counts only once the last beat is stored
   wire wr_arm = last_beat & wr_ap_q;
   wire [BANKS-1:0] wr_oh = bank_onehot(wr_bank_q);

   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      wire rd_hit = rd_arm & cmd_oh[b];
      ddrwp_bank #(
         .TRAS_CYC(TRAS_DLY)
      ) u_bank (
         .clk(CLOCK),
         .rst_n(RST_N),
         .tick(ck_rise),
         .act(act_cmd & cmd_oh[b]),
         .pre(pre_cmd & pre_sel[b]),
         .ap_arm(rd_hit | (wr_arm & wr_oh[b])),
         .ap_delay(rd_hit ? rd_ap_dly : TWR_DLY),
         .bank_open(bank_open[b]),
         .ap_fire(ap_fire[b])
      );
   end

   // Precharge start pulse, explicit or automatic
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         pre_evt_q <= '0;
      end else begin
         pre_evt_q <= ({BANKS{pre_cmd}} & pre_sel) | ap_fire;
      end
   end

   assign WR_VALID = wr_valid_q;
   assign WR_DATA = wr_data_q;
   assign WR_MASK = wr_mask_q;
   assign WR_BEAT = wr_beat_q;
   assign WR_BANK = wr_bank_q;
   assign WR_COL = wr_col_q;
   assign BANK_OPEN = bank_open;
   assign PRECHARGE_START = pre_evt_q;

   // =================================================================
   // Checks
   // =================================================================
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   a_write_decode: assert property (wr_start |=> wr_state_q == W_WAIT)
      else $error("write command not taken");
   a_write_latency: assert property (
      (wr_state_q == W_WAIT && wr_state_d == W_BURST) |-> wl_seen_q + 4'h1 == wl)
      else $error("burst opened off the write latency point");
   a_first_rising: assert property (beat_take && beat_q == 4'h0 |-> dqs_rise)
      else $error("first beat not on a rising strobe");
   a_burst_length: assert property (
      in_burst && wr_state_d == W_IDLE |-> beat_q + 4'h1 == bl_beats)
      else $error("burst closed at wrong beat count");
   a_data_ignored: assert property (!in_burst |=> !wr_valid_q)
      else $error("data taken outside a burst");
   a_mask_timing: assert property (beat_take |=> wr_mask_q == $past(dm_s))
      else $error("mask not taken with its data beat");
   a_read_no_mask: assert property (rd_cmd && wr_state_q == W_IDLE |=> !wr_valid_q)
      else $error("mask or data taken on a read");
   a_pre_all: assert property (pre_cmd && ap_flag |=> bank_open == '0 && pre_evt_q == '1)
      else $error("precharge all left a bank open");
   a_pre_single: assert property (
      pre_cmd && !ap_flag |=> !bank_open[$past(ba_s)])
      else $error("addressed bank not closed");

endmodule : ddrwp_core
`default_nettype wire

// [shared/ddrwp_pkg.sv]
`default_nettype none
// =====================================================================
// Shared constants for the write and precharge logic
// =====================================================================
package ddrwp_pkg;

   // =================================================================
   // Array geometry
   // =================================================================
   localparam int BANKS = 4;          // Internal banks
   localparam int BA_WIDTH = 2;       // Bank address pins
   localparam int ADDR_WIDTH = 13;    // Multiplexed address pins
   localparam int DQ_WIDTH = 16;      // Data pins
   localparam int DM_GROUP = 8;       // Data pins covered by one mask pin
   localparam int AP_BIT = 10;        // Address bit that selects auto or all-bank precharge

   // =================================================================
   // Burst shape
   // =================================================================
   localparam logic [3:0] BL4_BEATS = 4'h4;     // Beats of a short burst
   localparam logic [3:0] BL8_BEATS = 4'h8;     // Beats of a long burst
   localparam logic [7:0] BL4_HALF = 8'h02;     // BL/2 for a short burst
   localparam logic [7:0] BL8_HALF = 8'h04;     // BL/2 for a long burst
   localparam logic [7:0] BL8_PREFETCH = 8'h02; // Last prefetch lag of a long burst
   localparam logic [3:0] WL_OFFSET = 4'h1;     // Write latency is read latency less this

   // =================================================================
   // Timing, in picoseconds, and derived command clock counts
   // =================================================================
   localparam int CK_PERIOD_PS = 160000; // Command clock period
   localparam int TRAS_PS = 40000;       // Least active time
   localparam int TRTP_PS = 7500;        // Least read to precharge time
   localparam int TWR_PS = 15000;        // Write recovery time
   // Least times round up to whole command clocks
   localparam int TRAS_CK = (TRAS_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
   localparam int TRTP_CK = (TRTP_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
   localparam int TWR_CK = (TWR_PS + CK_PERIOD_PS - 1) / CK_PERIOD_PS;
   localparam logic [7:0] TRAS_DLY = 8'(TRAS_CK);
   localparam logic [7:0] TRTP_DLY = 8'(TRTP_CK);
   localparam logic [7:0] TWR_DLY = 8'(TWR_CK);

   // =================================================================
   // Write burst sequencer states
   // =================================================================
   typedef enum logic [1:0] {
      W_IDLE = 2'b00,
      W_WAIT = 2'b01,
      W_BURST = 2'b10
   } ddrwp_wstate_t;

endpackage : ddrwp_pkg
`default_nettype wire

// [hw/ddrwp_bank.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// One bank: open state, active-time lockout and auto-precharge timer
// =====================================================================
module ddrwp_bank
   import ddrwp_pkg::*;
#(
   parameter logic [7:0] TRAS_CYC = TRAS_DLY
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Command clock rising edge, one cycle
   input wire logic tick,
   // Commands aimed at this bank
   input wire logic act,
   input wire logic pre,
   // Auto-precharge request and its least delay in command clocks
   input wire logic ap_arm,
   input wire logic [7:0] ap_delay,
   // State
   output logic bank_open,
   output logic ap_fire
);

   logic open_q;          // Row is open
   logic pending_q;       // Auto-precharge waiting
   logic [7:0] tras_q;    // Command clocks left of least active time
   logic [7:0] ap_cnt_q;  // Command clocks left of the requested delay

   // Both counters are read before the decrement of this tick
   wire tras_due = (tras_q <= 8'h01);
   wire ap_due = (ap_cnt_q <= 8'h01);

   // Lockout holds the start back until active time has run out
   assign ap_fire = tick & pending_q & ap_due & tras_due;
   assign bank_open = open_q;

   // Open on activate, close on explicit or automatic precharge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         open_q <= 1'b0;
      end else if (act) begin
         open_q <= 1'b1;
      end else if (pre || ap_fire) begin
         open_q <= 1'b0;
      end
   end

   // Active time counter, loaded at activate
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tras_q <= 8'h00;
      end else if (act) begin
         tras_q <= TRAS_CYC;
      end else if (tick && tras_q != 8'h00) begin
         tras_q <= tras_q - 8'h01;
      end
   end

   // Pending flag; a new request wins over a completion in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_q <= 1'b0;
      end else if (ap_arm) begin
         pending_q <= 1'b1;
      end else if (ap_fire || pre) begin
         pending_q <= 1'b0;
      end
   end

   // Delay counter of the pending request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ap_cnt_q <= 8'h00;
      end else if (ap_arm) begin
         ap_cnt_q <= ap_delay;
      end else if (tick && ap_cnt_q != 8'h00) begin
         ap_cnt_q <= ap_cnt_q - 8'h01;
      end
   end

   // =================================================================
   // Checks
   // =================================================================
   a_ap_tras_hold: assert property (@(posedge clk) disable iff (!rst_n)
      ap_fire |-> (tras_q <= 8'h01) && open_q)
      else $error("auto precharge began before active time ran out");

   a_ap_delay_met: assert property (@(posedge clk) disable iff (!rst_n)
      (ap_arm && tick && ap_delay > 8'h01) |=> !ap_fire)
      else $error("auto precharge began before its delay");

endmodule : ddrwp_bank
`default_nettype wire

// [verif/ddrwp_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Controller model: command clock, commands, strobe and write data
// =====================================================================
module ddrwp_ctrl_model
   import ddrwp_pkg::*;
(
   // Pacing clock
   input wire logic clk,
   // Command pins
   output logic ck,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [BA_WIDTH-1:0] ba,
   output logic [ADDR_WIDTH-1:0] addr,
   // Write data pins
   output logic dqs,
   output logic [DQ_WIDTH-1:0] dq,
   output logic [DQ_WIDTH/DM_GROUP-1:0] dm
);
   int ck_count; // Command clock rises issued so far
   // Levels set by the tasks; the pins follow them continuously
   logic ck_drv, cs_n_drv, ras_n_drv, cas_n_drv, we_n_drv, dqs_drv;
   logic [BA_WIDTH-1:0] ba_drv;
   logic [ADDR_WIDTH-1:0] addr_drv;
   logic [DQ_WIDTH-1:0] dq_drv;
   logic [DQ_WIDTH/DM_GROUP-1:0] dm_drv;

   assign ck = ck_drv;
   assign cs_n = cs_n_drv;
   assign ras_n = ras_n_drv;
   assign cas_n = cas_n_drv;
   assign we_n = we_n_drv;
   assign dqs = dqs_drv;
   assign ba = ba_drv;
   assign addr = addr_drv;
   assign dq = dq_drv;
   assign dm = dm_drv;

   // Idle levels at time zero
   initial begin
      {ck_drv, dqs_drv, cs_n_drv, ras_n_drv, cas_n_drv, we_n_drv} = 6'h0F;
      ba_drv = 2'h0;
      addr_drv = 13'h0000;
      dq_drv = 16'h0000;
      dm_drv = 2'h0;
      ck_count = 0;
   end

   // Half a command clock: four system clocks, strobe one clock late.
   // Released lines toggle so stale values can never pass for data.
   task automatic half(input logic ckv, input int mode, input logic [15:0] d,
         input logic [1:0] m);
      ck_drv = ckv;
      dq_drv = (mode == 0) ? ~dq_drv : d;
      dm_drv = (mode == 0) ? ~dm_drv : m;
      @(negedge clk);
      dqs_drv = (mode == 0) ? ~dqs_drv : ((mode == 2) & ckv);
      repeat (3) @(negedge clk);
   endtask : half

   // One command clock period with a command held all through it
   task automatic tick(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
         input int mode, input logic [15:0] d0, input logic [15:0] d1,
         input logic [1:0] m0, input logic [1:0] m1);
      ck_count++;
      {cs_n_drv, ras_n_drv, cas_n_drv, we_n_drv} = c;
      ba_drv = c[3] ? ~ba_drv : b;
      addr_drv = c[3] ? ~addr_drv : a;
      half(1'b1, mode, d0, m0);
      half(1'b0, mode, d1, m1);
   endtask : tick

   // Deselected periods
   task automatic idle(input int n);
      repeat (n) tick(4'hF, 2'h0, 13'h0000, 0, 16'h0000, 16'h0000, 2'h0, 2'h0);
   endtask : idle

   // Single command, strobe released
   task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
      tick(c, b, a, 0, 16'h0000, 16'h0000, 2'h0, 2'h0);
   endtask : cmd

   // Write command, preamble, burst, then two released periods
   task automatic write_burst(input logic [1:0] b, input logic [12:0] a, input int wl,
         input int bl, input logic [15:0] base, input logic [1:0] mk);
      int n;
      int k;
      for (n = 0; n < wl + bl / 2 + 2; n++) begin
         k = 2 * (n - wl);
         tick((n == 0) ? 4'h4 : 4'hF, b, a,
            (n == wl - 1) ? 1 : ((n >= wl && n < wl + bl / 2) ? 2 : 0),
            base + 16'(k), base + 16'(k + 1), mk ^ 2'(k), mk ^ 2'(k + 1));
      end
   endtask : write_burst
endmodule : ddrwp_ctrl_model
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Testbench for the write and precharge core
// =====================================================================
module tb
   import ddrwp_pkg::*;
;
   logic clock;
   logic rst_n;
   logic [2:0] cas_latency;
   logic [2:0] add_latency;
   logic burst_len8;
   wire logic ck, cs_n, ras_n, cas_n, we_n, dqs;
   wire logic [1:0] ba;
   wire logic [12:0] addr;
   wire logic [15:0] dq;
   wire logic [1:0] dm;
   logic wr_valid;
   logic [15:0] wr_data;
   logic [1:0] wr_mask;
   logic [2:0] wr_beat;
   logic [1:0] wr_bank;
   logic [12:0] wr_col;
   logic [3:0] bank_open;
   logic [3:0] precharge_start;
   int miscompares;
   int samples_checked;
   // Captured beats and precharge pulses
   logic [15:0] got_d[$];
   logic [1:0] got_m[$];
   logic [2:0] got_b[$];
   int pre_ck[$];
   logic [3:0] pre_mk[$];

   ddrwp_core dut (.CLOCK(clock), .RST_N(rst_n), .CK(ck), .CS_N(cs_n), .RAS_N(ras_n),
      .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .ADDR(addr), .DQS_IN(dqs), .DQ_IN(dq), .DM(dm),
      .CAS_LATENCY(cas_latency), .ADD_LATENCY(add_latency), .BURST_LEN8(burst_len8),
      .WR_VALID(wr_valid), .WR_DATA(wr_data), .WR_MASK(wr_mask), .WR_BEAT(wr_beat),
      .WR_BANK(wr_bank), .WR_COL(wr_col), .BANK_OPEN(bank_open),
      .PRECHARGE_START(precharge_start));

   ddrwp_ctrl_model u_ctrl (.clk(clock), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .ba(ba), .addr(addr), .dqs(dqs), .dq(dq), .dm(dm));

   // 50 MHz system clock
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Sample mid-cycle, where registered outputs have settled
   always @(negedge clock) begin
      if (wr_valid === 1'b1) begin
         got_d.push_back(wr_data);
         got_m.push_back(wr_mask);
         got_b.push_back(wr_beat);
      end
      if ((|precharge_start) === 1'b1) begin
         pre_ck.push_back(u_ctrl.ck_count);
         pre_mk.push_back(precharge_start);
      end
   end

   // =================================================================
   // Comparison and closing
   // =================================================================
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_val

   task automatic check_num(input int got, input int exp);
      samples_checked++;
      if (got != exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_num

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test

   task automatic clear_q();
      got_d.delete();
      got_m.delete();
      got_b.delete();
      pre_ck.delete();
      pre_mk.delete();
   endtask : clear_q

   // =================================================================
   // Scenarios
   // =================================================================
   // Single-bank and all-bank precharge masks
   task automatic scn_prech();
      int b;
      clear_q();
      for (b = 0; b < BANKS; b++) u_ctrl.cmd(4'h3, 2'(b), 13'h0000);
      u_ctrl.idle(1);
      check_val(32'(bank_open), 32'hF);
      for (b = 0; b < BANKS; b++) begin
         u_ctrl.cmd(4'h2, 2'(b), 13'h0000);
         u_ctrl.idle(1);
         check_val(32'(bank_open), 32'(4'(4'hF << (b + 1))));
         check_val(32'((pre_mk.size() > b) ? pre_mk[b] : 4'h0), 32'(1 << b));
      end
      for (b = 0; b < BANKS; b++) u_ctrl.cmd(4'h3, 2'(b), 13'h0000);
      u_ctrl.idle(1);
      u_ctrl.cmd(4'h2, 2'h2, 13'h0400);
      u_ctrl.idle(1);
      check_val(32'(bank_open), 32'h0);
      check_val(32'(pre_mk[pre_mk.size() - 1]), 32'hF);
   endtask : scn_prech

   // Write burst with junk strobes around the window
   task automatic scn_write(input int al, input int cl, input logic b8, input logic [1:0] bk,
         input logic [12:0] col, input logic ap);
      int wl;
      int bl;
      int n;
      int i;
      logic [15:0] base;
      wl = al + cl - 1;
      bl = b8 ? 8 : 4;
      add_latency = 3'(al);
      cas_latency = 3'(cl);
      burst_len8 = b8;
      u_ctrl.cmd(4'h3, bk, 13'h0000);
      u_ctrl.idle(1);
      clear_q();
      n = u_ctrl.ck_count + 1;
      base = 16'h3C00 + 16'(n * 16);
      u_ctrl.write_burst(bk, col | (13'(ap) << AP_BIT), wl, bl, base, bk);
      u_ctrl.idle(2);
      check_num(got_d.size(), bl);
      for (i = 0; i < bl && i < got_d.size(); i++) begin
         check_val(32'(got_d[i]), 32'(base + 16'(i)));
         check_val(32'(got_m[i]), 32'(bk ^ 2'(i)));
         check_val(32'(got_b[i]), 32'(i));
      end
      check_val(32'({wr_bank, wr_col & ~(13'h1 << AP_BIT)}), 32'({bk, col}));
      if (ap) begin
         check_num(pre_ck.size(), 1);
         check_num((pre_ck.size() > 0 && (pre_ck[0] - n - wl - bl / 2) inside {0, 1})
            ? 1 : 0, 1);
      end else begin
         check_num(pre_ck.size(), 0);
         check_val(32'(bank_open[bk]), 32'h1);
         u_ctrl.cmd(4'h2, bk, 13'h0000);
         u_ctrl.idle(2);
      end
      check_val(32'(bank_open), 32'h0);
   endtask : scn_write

   // Read, spaced precharge, then read with auto-precharge
   task automatic scn_read(input int al, input logic b8, input logic [1:0] bk);
      int bl;
      int n;
      int ex;
      bl = b8 ? 8 : 4;
      add_latency = 3'(al);
      cas_latency = 3'h3;
      burst_len8 = b8;
      clear_q();
      u_ctrl.cmd(4'h3, bk, 13'h0000);
      u_ctrl.idle(1);
      u_ctrl.cmd(4'h5, bk, 13'h0008);
      u_ctrl.idle(al + bl / 2 - 1);
      u_ctrl.cmd(4'h2, bk, 13'h0000);
      u_ctrl.idle(2);
      check_num(pre_ck.size(), 1);
      u_ctrl.cmd(4'h3, bk, 13'h0000);
      u_ctrl.idle(1);
      n = u_ctrl.ck_count + 1;
      u_ctrl.cmd(4'h5, bk, 13'h0408);
      u_ctrl.idle(al + bl / 2 + 4);
      ex = al + (b8 ? 2 : 0) + TRTP_CK;
      if (al + bl / 2 > ex) begin
         ex = al + bl / 2;
      end
      check_num(got_d.size(), 0);
      check_num(pre_ck.size(), 2);
      check_num((pre_ck.size() > 1) ? pre_ck[1] : -1, n + ex);
      check_val(32'(bank_open), 32'h0);
   endtask : scn_read

   // Bound on the whole run
   initial begin
      repeat (100000) @(posedge clock);
      miscompares++;
      finish_test();
   end

   // Main sequence
   initial begin
      rst_n = 1'b0;
      cas_latency = 3'h3;
      add_latency = 3'h0;
      burst_len8 = 1'b0;
      miscompares = 0;
      samples_checked = 0;
      repeat (6) @(posedge clock);
      @(negedge clock);
      check_val(32'({wr_valid, bank_open, precharge_start}), 32'h0);
      rst_n = 1'b1;
      u_ctrl.idle(2);
      scn_prech();
      scn_write(0, 2, 1'b0, 2'h1, 13'h0014, 1'b0);
      scn_write(0, 3, 1'b1, 2'h2, 13'h01F8, 1'b1);
      scn_write(2, 4, 1'b0, 2'h3, 13'h0004, 1'b1);
      scn_write(1, 5, 1'b1, 2'h0, 13'h03F0, 1'b0);
      scn_read(0, 1'b0, 2'h0);
      scn_read(0, 1'b1, 2'h1);
      scn_read(2, 1'b1, 2'h2);
      scn_read(1, 1'b0, 2'h3);
      finish_test();
   end
endmodule : tb
`default_nettype wire
